// file: src/ubb_bridge.sv
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - usb suspend signalling detected: enter suspend, assert both indicators
// - after device reset indicators stay asserted until host configures the device
// - leave suspend on resume seen or sent, usb bus reset, or device reset
// - leaving suspend on resume or usb bus reset deasserts both indicators
// - while held in reset both indicators are released, not driven
// - while driven, the indicator pair shows opposite levels of one state
// - controller carries all usb/uart data and host uart control commands
// - flow control by rts/cts, dtr/dsr and x-on/x-off characters
// - host configuration requests set the character format and baud rate
// - 5 to 8 data bits; 1, 1.5 or 2 stops, 1.5 only with 5 bits
// - parity none, even, odd, mark or space
// - baud generator gives the listed rates from 300 to 921600
// - 921600 baud only with 7 or 8 data bits
// - unprogrammed rom locations report built-in default descriptor values
// - host writes the configuration rom over usb; device accepts the writes
// - one-time variant: each location written once, later writes change nothing
// - rewritable variant: lock bit blocks any further descriptor change
// - serial string at most 63, product string at most 126 characters
module ubb_bridge import ubb_pkg::*; #(
   parameter bit OTP = 1'b0,
   parameter logic [15:0] VID_DEF = 16'h1234,  // arbitrary value
   parameter logic [15:0] PID_DEF = 16'h5678,  // arbitrary value
   parameter logic [15:0] REL_DEF = 16'h0200,  // arbitrary value
   parameter logic [47:0] SER_DEF = 48'h313233343536  // arbitrary value
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic usb_suspend_det,
   input wire logic usb_resume_det,
   input wire logic usb_bus_reset,
   input wire logic usb_configured,
   input wire logic bus_power_sense,
   input wire logic rxd,
   input wire logic cts_n,
   input wire logic dsr_n,
   input wire logic dcd_n,
   input wire logic ri_n,
   output logic txd,
   output logic rts_n,
   output logic dtr_n,
   output logic suspend,
   output logic suspend_n,
   output logic suspend_oe_n
);
   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [19:0] baud_div(input logic [4:0] i);
      baud_div = 20'(CLK_HZ / BAUD_TAB[0]);
      for (int k = 0; k < BAUD_N; k++) begin
         if (i == 5'(k)) begin
            baud_div = 20'((CLK_HZ + BAUD_TAB[k] / 2) / BAUD_TAB[k]);
         end
      end
   endfunction
   function automatic logic par_bit(input logic [7:0] d, input ubb_fmt_s f);
      logic [7:0] m;
      m = d & (8'hFF >> (2'h3 - f.bits));
      unique case (f.parity)
         PAR_EVEN: par_bit = ^m;
         PAR_ODD: par_bit = ~^m;
         PAR_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction
   function automatic logic fmt_ok(input ubb_fmt_s f, input logic [4:0] b);
      fmt_ok = (f.stop != 2'h3) && (f.parity <= PAR_SPACE) && (b <= BAUD_TOP)
         && !(f.stop == STOP_15 && f.bits != BITS_5) && !(b == BAUD_TOP && f.bits < BITS_7);
   endfunction
   // ***********************************************
   // register bus
   // ***********************************************
   logic [5:0] ctrl;
   ubb_fmt_s fmt;
   logic [4:0] baud;
   logic [19:0] div;
   logic cfg_err;
   logic [7:0] tx_hold;
   logic tx_hold_v;
   logic [7:0] rx_hold;
   logic rx_hold_v;
   logic rx_perr;
   logic rx_done;
   logic [7:0] rx_shift;
   logic xoff_seen;
   logic [3:0] rom_idx;
   logic [7:0] rom [ROM_DEPTH];
   logic [ROM_DEPTH-1:0] prog;
   logic rom_req;
   logic rom_we;
   logic rom_rej;
   logic [7:0] rom_rd;
   ubb_susp_e sstate;
   ubb_ser_e tstate;
   ubb_ser_e rstate;
   logic wr_ctrl;
   logic wake;
   assign wr_ctrl = reg_wr && reg_addr == A_CTRL;
   assign wake = wr_ctrl && reg_wdata[CTL_WAKE];
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= CTRL_RST;
         fmt <= FMT_RST;
         baud <= BAUD_RST;
         cfg_err <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= reg_wdata[5:0] | {ctrl[CTL_LOCK], 5'h00};
         end
         if (reg_wr && reg_addr == A_FMT) begin
            if (fmt_ok(reg_wdata[6:0], baud)) begin
               fmt <= reg_wdata[6:0];
            end else begin
               cfg_err <= 1'b1;
            end
         end else if (reg_wr && reg_addr == A_BAUD) begin
            if (fmt_ok(fmt, reg_wdata[4:0])) begin
               baud <= reg_wdata[4:0];
            end else begin
               cfg_err <= 1'b1;
            end
         end else if (reg_rd && reg_addr == A_STAT) begin
            cfg_err <= 1'b0;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div <= baud_div(BAUD_RST);
      end else begin
         div <= baud_div(baud);
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            A_CTRL: reg_rdata <= {26'h0, ctrl};
            A_FMT: reg_rdata <= {25'h0, fmt};
            A_BAUD: reg_rdata <= {27'h0, baud};
            A_RXD: reg_rdata <= {24'h0, rx_hold};
            A_STAT: reg_rdata <= {19'h0, sstate, bus_power_sense, ri_n, dcd_n, dsr_n, cts_n, xoff_seen,
               rx_perr, cfg_err, rx_hold_v, tx_hold_v, tstate != SR_IDLE};
            A_RADR: reg_rdata <= {28'h0, rom_idx};
            A_RDAT: reg_rdata <= {23'h0, prog[rom_idx], rom_rd};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
   // ***********************************************
   // suspend indication
   // ***********************************************
   logic rel;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sstate <= SU_UNCONF;
      end else begin
         unique case (sstate)
            SU_UNCONF: if (usb_configured) begin
               sstate <= SU_ACTIVE;
            end
            SU_ACTIVE: if (usb_suspend_det && !usb_bus_reset && !usb_resume_det) begin
               sstate <= SU_SUSP;
            end
            SU_SUSP: if (usb_resume_det || usb_bus_reset || wake) begin
               sstate <= SU_ACTIVE;
            end
            default: sstate <= SU_UNCONF;
         endcase
      end
   end
   always_ff @(posedge clk_sys) begin
      rel <= rst;
   end
   assign suspend_oe_n = rel;
   assign suspend = rel || sstate != SU_ACTIVE;
   assign suspend_n = rel || sstate == SU_ACTIVE;
   // ***********************************************
   // transmitter
   // ***********************************************
   logic [19:0] tcnt;
   logic [19:0] tlim;
   logic [2:0] tbit;
   logic [7:0] tsh;
   logic tx_go;
   // cts high holds the line idle
   assign tx_go = tx_hold_v && !(ctrl[CTL_RTSCTS] && cts_n) && !(ctrl[CTL_DTRDSR] && dsr_n)
      && !(ctrl[CTL_XONXOFF] && xoff_seen);
   // 1.5 stop is three half bits, so the stop limit adds half of div to div
   assign tlim = (tstate != SR_STOP) ? div : (fmt.stop == STOP_15) ? div + (div >> 1) :
      (fmt.stop == STOP_2) ? {div[18:0], 1'b0} : div;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_hold <= 8'h00;
         tx_hold_v <= 1'b0;
      end else if (reg_wr && reg_addr == A_TXD && !tx_hold_v) begin
         tx_hold <= reg_wdata[7:0];
         tx_hold_v <= 1'b1;
      end else if (tstate == SR_IDLE && tx_go) begin
         tx_hold_v <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tstate <= SR_IDLE;
         tcnt <= 20'h0;
         tbit <= 3'h0;
         tsh <= 8'h00;
         txd <= 1'b1;
      end else if (tstate == SR_IDLE) begin
         tcnt <= 20'h0;
         tbit <= 3'h0;
         txd <= 1'b1;
         if (tx_go) begin
            tsh <= tx_hold;
            tstate <= SR_START;
            txd <= 1'b0;
         end
      end else if (tcnt < tlim - 20'h1) begin
         tcnt <= tcnt + 20'h1;
      end else begin
         tcnt <= 20'h0;
         unique case (tstate)
            SR_START: begin
               tstate <= SR_DATA;
               txd <= tsh[0];
            end
            SR_DATA: if (tbit == {1'b1, fmt.bits}) begin
               tstate <= (fmt.parity == PAR_NONE) ? SR_STOP : SR_PAR;
               txd <= (fmt.parity == PAR_NONE) ? 1'b1 : par_bit(tsh, fmt);
            end else begin
               tbit <= tbit + 3'h1;
               txd <= tsh[3'(tbit + 3'h1)];
            end
            SR_PAR: begin
               tstate <= SR_STOP;
               txd <= 1'b1;
            end
            default: tstate <= SR_IDLE;
         endcase
      end
   end
   // ***********************************************
   // receiver
   // ***********************************************
   logic [19:0] rcnt;
   logic [2:0] rbit;
   logic rpe;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rstate <= SR_IDLE;
         rcnt <= 20'h0;
         rbit <= 3'h0;
         rx_shift <= 8'h00;
         rpe <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         if (rstate == SR_IDLE) begin
            rcnt <= 20'h0;
            rbit <= 3'h0;
            rpe <= 1'b0;
            rstate <= rxd ? SR_IDLE : SR_START;
         end else if (rcnt < ((rstate == SR_START) ? (div >> 1) : div) - 20'h1) begin
            rcnt <= rcnt + 20'h1;
         end else begin
            rcnt <= 20'h0;
            unique case (rstate)
               SR_START: begin
                  rstate <= rxd ? SR_IDLE : SR_DATA;
                  rx_shift <= 8'h00;
               end
               SR_DATA: begin
                  rx_shift[rbit] <= rxd;
                  rbit <= rbit + 3'h1;
                  if (rbit == {1'b1, fmt.bits}) begin
                     rstate <= (fmt.parity == PAR_NONE) ? SR_STOP : SR_PAR;
                  end
               end
               SR_PAR: begin
                  rpe <= rxd != par_bit(rx_shift, fmt);
                  rstate <= SR_STOP;
               end
               default: begin
                  rstate <= SR_IDLE;
                  rx_done <= 1'b1;
               end
            endcase
         end
      end
   end
   // set wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_hold <= 8'h00;
         rx_hold_v <= 1'b0;
         rx_perr <= 1'b0;
         xoff_seen <= 1'b0;
      end else begin
         if (rx_done) begin
            rx_hold <= rx_shift;
            rx_hold_v <= 1'b1;
            rx_perr <= rpe;
         end else if (reg_rd && reg_addr == A_RXD) begin
            rx_hold_v <= 1'b0;
            rx_perr <= 1'b0;
         end
         if (rx_done && ctrl[CTL_XONXOFF] && rx_shift == XOFF) begin
            xoff_seen <= 1'b1;
         end else if ((rx_done && rx_shift == XON) || !ctrl[CTL_XONXOFF]) begin
            xoff_seen <= 1'b0;
         end
      end
   end
   // rts tracks room, dtr from host
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rts_n <= 1'b1;
         dtr_n <= 1'b1;
      end else begin
         rts_n <= ctrl[CTL_RTSCTS] ? rx_hold_v : !ctrl[CTL_RTS];
         dtr_n <= !ctrl[CTL_DTR];
      end
   end
   // ***********************************************
   // configuration rom
   // ***********************************************
   // host write path
   assign rom_req = reg_wr && reg_addr == A_RDAT;
   assign rom_rej = (OTP ? prog[rom_idx] : ctrl[CTL_LOCK])
      || (rom_idx == R_SERLEN && reg_wdata[7:0] > SER_MAX) || (rom_idx == R_PRODLEN && reg_wdata[7:0] > PROD_MAX);
   assign rom_we = rom_req && !rom_rej;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rom_idx <= 4'h0;
      end else if (reg_wr && reg_addr == A_RADR) begin
         rom_idx <= reg_wdata[3:0];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prog <= '0;
      end else if (rom_we) begin
         prog[rom_idx] <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rom_we) begin
         rom[rom_idx] <= reg_wdata[7:0];
      end
   end
   always_comb begin
      unique case (rom_idx)
         4'h0: rom_rd = VID_DEF[7:0];
         4'h1: rom_rd = VID_DEF[15:8];
         4'h2: rom_rd = PID_DEF[7:0];
         4'h3: rom_rd = PID_DEF[15:8];
         R_ATTR: rom_rd = ATTR_DEF;
         R_MAXP: rom_rd = MAXP_DEF;
         4'h6: rom_rd = REL_DEF[7:0];
         4'h7: rom_rd = REL_DEF[15:8];
         R_SERLEN: rom_rd = OTP ? OTP_SERLEN : 8'h06;
         R_PRODLEN: rom_rd = 8'h00;
         default: rom_rd = SER_DEF[8*(4'hF - rom_idx) +: 8];
      endcase
      if (prog[rom_idx]) begin
         rom_rd = rom[rom_idx];
      end
   end
   // ***********************************************
   // assertions
   // ***********************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_susp_enter: assert property (sstate == SU_ACTIVE && usb_suspend_det && !usb_bus_reset && !usb_resume_det
      |=> suspend && !suspend_n) else $error("suspend not entered");
   a_reset_hold: assert property (disable iff (1'b0) rst ##1 !rst |=> suspend && !suspend_n && !suspend_oe_n)
      else $error("indicators not asserted after reset");
   a_susp_exit: assert property (sstate == SU_SUSP && (usb_resume_det || usb_bus_reset || wake)
      |=> !suspend && suspend_n) else $error("suspend not left");
   a_pair_opposite: assert property (!suspend_oe_n |-> suspend != suspend_n)
      else $error("indicator pair not complementary");
   a_reset_release: assert property (disable iff (1'b0) rst |=> suspend_oe_n)
      else $error("indicators driven in reset");
   a_stop_legal: assert property ((fmt.stop != STOP_15 || fmt.bits == BITS_5)
      && (baud != BAUD_TOP || fmt.bits >= BITS_7)) else $error("illegal format held");
   a_cts_block: assert property (ctrl[CTL_RTSCTS] && cts_n && tstate == SR_IDLE |=> tstate == SR_IDLE)
      else $error("start while cts high");
   a_frame_start: assert property (tstate == SR_IDLE ##1 tstate == SR_START |-> !txd [*2])
      else $error("start bit not low");
   a_rom_guard: assert property (rom_req && (OTP ? prog[rom_idx] : ctrl[CTL_LOCK]) |=> $stable(prog)
      && rom_rd == $past(rom_rd)) else $error("protected rom changed");
   a_data_path: assert property (reg_wr && reg_addr == A_TXD && !tx_hold_v |=> tx_hold_v)
      else $error("host data not taken");
   c_suspend: cover property (sstate == SU_SUSP ##1 sstate == SU_ACTIVE);
   c_tx_char: cover property (tstate == SR_STOP ##1 tstate == SR_IDLE);
   c_rx_char: cover property (rx_done);
   c_rom_write: cover property (rom_we);
endmodule

// file: src/ubb_pkg.sv
package ubb_pkg;
   // ***********************************************
   // clock, register map
   // ***********************************************
   localparam int CLK_HZ = 40_000_000;
   localparam int ADDR_W = 8;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_FMT = 8'h04;
   localparam logic [7:0] A_BAUD = 8'h08;
   localparam logic [7:0] A_TXD = 8'h0C;
   localparam logic [7:0] A_RXD = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [7:0] A_RADR = 8'h18;
   localparam logic [7:0] A_RDAT = 8'h1C;
   localparam int CTL_RTSCTS = 0;
   localparam int CTL_DTRDSR = 1;
   localparam int CTL_XONXOFF = 2;
   localparam int CTL_RTS = 3;
   localparam int CTL_DTR = 4;
   localparam int CTL_LOCK = 5;
   localparam int CTL_WAKE = 6;
   localparam logic [5:0] CTRL_RST = 6'h00;
   // ***********************************************
   // character format and baud table
   // ***********************************************
   typedef struct packed {
      logic [2:0] parity;
      logic [1:0] stop;
      logic [1:0] bits;
   } ubb_fmt_s;
   localparam logic [2:0] PAR_NONE = 3'h0;
   localparam logic [2:0] PAR_EVEN = 3'h1;
   localparam logic [2:0] PAR_ODD = 3'h2;
   localparam logic [2:0] PAR_MARK = 3'h3;
   localparam logic [2:0] PAR_SPACE = 3'h4;
   localparam logic [1:0] STOP_1 = 2'h0;
   localparam logic [1:0] STOP_15 = 2'h1;
   localparam logic [1:0] STOP_2 = 2'h2;
   localparam logic [1:0] BITS_5 = 2'h0;
   localparam logic [1:0] BITS_7 = 2'h2;
   localparam logic [6:0] FMT_RST = 7'h03;
   localparam int BAUD_N = 29;
   localparam logic [4:0] BAUD_TOP = 5'h1C;
   localparam logic [4:0] BAUD_RST = 5'h08;
   localparam int unsigned BAUD_TAB [0:28] = '{300, 600, 1200, 1800, 2400, 4000, 4800, 7200, 9600, 14400,
      16000, 19200, 28800, 38400, 51200, 56000, 57600, 64000, 76800, 115200, 128000, 153600, 230400, 250000,
      256000, 460800, 500000, 576000, 921600};
   localparam logic [7:0] XON = 8'h11;
   localparam logic [7:0] XOFF = 8'h13;
   // ***********************************************
   // configuration rom layout
   // ***********************************************
   localparam int ROM_DEPTH = 16;
   localparam logic [3:0] R_ATTR = 4'h4;
   localparam logic [3:0] R_MAXP = 4'h5;
   localparam logic [3:0] R_SERLEN = 4'h8;
   localparam logic [3:0] R_PRODLEN = 4'h9;
   localparam logic [7:0] ATTR_DEF = 8'h80;
   localparam logic [7:0] MAXP_DEF = 8'h32;
   localparam logic [7:0] SER_MAX = 8'h3F;
   localparam logic [7:0] PROD_MAX = 8'h7E;
   localparam logic [7:0] OTP_SERLEN = 8'h08;
   typedef enum logic [1:0] {SU_UNCONF = 2'b00, SU_ACTIVE = 2'b01, SU_SUSP = 2'b10} ubb_susp_e;
   typedef enum logic [2:0] {
      SR_IDLE = 3'b000, SR_START = 3'b001, SR_DATA = 3'b010, SR_PAR = 3'b011, SR_STOP = 3'b100
   } ubb_ser_e;
endpackage

// file: tb/ubb_peer.sv
`timescale 1ns/1ps
// ****************
// serial peer model
// ****************
module ubb_peer (
   input wire logic clk_sys,
   output logic rxd,
   output logic [3:0] modem_n
);
   initial begin
      rxd = 1'b1;
      modem_n = 4'hF;
   end
   task automatic set_modem(input logic [3:0] v);
      @(posedge clk_sys);
      modem_n <= v;
   endtask
   // low start, lsb first, high stop
   task automatic send(input logic [7:0] d, input int div);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk_sys);
         rxd <= f[i];
         repeat (div - 1) @(posedge clk_sys);
      end
   endtask
endmodule

// file: tb/ubb_bridge_test.sv
`timescale 1ns/1ps
module ubb_bridge_test import ubb_pkg::*;;
   logic clk_sys, rst, reg_wr, reg_rd, bus_power_sense, rxd, txd, rts_n, dtr_n;
   logic suspend, suspend_n, suspend_oe_n;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [3:0] uev, modem_n;
   logic [15:0] lf;
   logic [6:0] f;
   int n_mismatch, n_checks, div, lows;
   int q[$];
   ubb_bridge i_ubb_bridge (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .usb_suspend_det(uev[0]),
      .usb_resume_det(uev[1]), .usb_bus_reset(uev[2]), .usb_configured(uev[3]),
      .bus_power_sense(bus_power_sense), .rxd(rxd), .cts_n(modem_n[0]), .dsr_n(modem_n[1]),
      .dcd_n(modem_n[2]), .ri_n(modem_n[3]), .txd(txd), .rts_n(rts_n), .dtr_n(dtr_n),
      .suspend(suspend), .suspend_n(suspend_n), .suspend_oe_n(suspend_oe_n));
   ubb_peer i_ubb_peer (.clk_sys(clk_sys), .rxd(rxd), .modem_n(modem_n));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ****************
   // bus and model tasks
   // ****************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(nm, e, rv);
   endtask
   task automatic pulse(input int i);
      @(posedge clk_sys);
      uev[i] <= 1'b1;
      @(posedge clk_sys);
      uev <= 4'h0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      #1 chk("released", 32'h7, {suspend_oe_n, suspend, suspend_n});
      @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 chk("unconf", 32'h2, {suspend_oe_n, suspend, suspend_n});
   endtask
   // expected bit stream, sampled mid-bit; slow waits are bounded
   task automatic tx_chk(input logic [7:0] d, input logic [6:0] fm);
      logic [7:0] m;
      int k;
      m = d & (8'hFF >> (3 - fm[1:0]));
      q = {};
      q.push_back(0);
      for (int i = 0; i < fm[1:0] + 5; i++) q.push_back(d[i]);
      if (fm[6:4] != PAR_NONE) q.push_back(fm[6:4] == PAR_EVEN ? ^m : fm[6:4] == PAR_ODD ? ~^m : fm[6:4] == PAR_MARK);
      q.push_back(1);
      k = 0;
      while (txd !== 1'b0 && k < 3000) begin
         @(posedge clk_sys);
         #1 k++;
      end
      repeat (div / 2) @(posedge clk_sys);
      foreach (q[i]) begin
         #1 chk("txd bit", q[i], txd);
         repeat (div) @(posedge clk_sys);
      end
   endtask
   task automatic romc(input logic [3:0] i, input logic [8:0] w, input logic [31:0] e);
      wr(A_RADR, {28'h0, i});
      if (w[8]) wr(A_RDAT, {24'h0, w[7:0]});
      rdc("rom", A_RDAT, e);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ****************
   // watchdog and sequence
   // ****************
   initial begin
      repeat (80000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      {reg_wr, reg_rd, reg_addr, reg_wdata, uev} = '0;
      bus_power_sense = 1'b1;
      lf = 16'h8F00;
      n_mismatch = 0;
      n_checks = 0;
      do_reset();
      rdc("ctrl", A_CTRL, 32'h0);
      rdc("fmt", A_FMT, 32'h3);
      rdc("baud", A_BAUD, 32'h8);
      rdc("unmapped", 8'h20, 32'h0);
      $display("test registers done");
      pulse(3);
      chk("active", 32'h1, {suspend, suspend_n});
      for (int i = 0; i < 3; i++) begin
         pulse(0);
         chk("suspended", 32'h2, {suspend_oe_n, suspend, suspend_n});
         if (i < 2) pulse(i + 1);
         else wr(A_CTRL, 32'h40);
         repeat (2) @(posedge clk_sys);
         #1 chk("resumed", 32'h1, {suspend, suspend_n});
      end
      $display("test suspend done");
      wr(A_BAUD, 32'd26);
      div = (CLK_HZ + BAUD_TAB[26] / 2) / BAUD_TAB[26];
      for (int b = 0; b < 4; b++) begin
         for (int p = 0; p < 5; p++) begin
            f = {3'(p), (b == 0) ? STOP_15 : (p % 2 ? STOP_2 : STOP_1), 2'(b)};
            wr(A_FMT, {25'h0, f});
            lf = lfsr(lf);
            wr(A_TXD, {24'h0, lf[7:0]});
            tx_chk(lf[7:0], f);
         end
      end
      $display("test formats done");
      wr(A_FMT, 32'h05);
      rdc("fmt stop", A_FMT, 32'h43);
      wr(A_FMT, 32'h00);
      wr(A_BAUD, 32'd28);
      rdc("baud 5 bit", A_BAUD, 32'd26);
      rd(A_STAT);
      chk("cfg err", 32'h1, rv[3]);
      chk("stat state power", 32'h3, rv[12:10]);
      wr(A_FMT, 32'h03);
      wr(A_BAUD, 32'd28);
      rdc("baud top", A_BAUD, 32'd28);
      div = (CLK_HZ + BAUD_TAB[28] / 2) / BAUD_TAB[28];
      $display("test refusals done");
      wr(A_CTRL, 32'h01);
      lf = lfsr(lf);
      wr(A_TXD, {24'h0, lf[7:0]});
      lows = 0;
      repeat (300) begin
         @(posedge clk_sys);
         #1 lows += (txd !== 1'b1);
      end
      chk("cts hold", 32'h0, lows);
      chk("rts_n room", 32'h0, rts_n);
      i_ubb_peer.set_modem(4'hE);
      tx_chk(lf[7:0], 7'h03);
      wr(A_CTRL, 32'h14);
      repeat (2) @(posedge clk_sys);
      #1 chk("dtr_n", 32'h0, dtr_n);
      lf = lfsr(lf);
      i_ubb_peer.send(lf[7:0], div);
      repeat (div) @(posedge clk_sys);
      rdc("rx byte", A_RXD, {24'h0, lf[7:0]});
      for (int i = 0; i < 2; i++) begin
         i_ubb_peer.send(i ? XON : XOFF, div);
         repeat (div) @(posedge clk_sys);
         rd(A_STAT);
         chk("xoff seen", 32'(1 - i), rv[5]);
      end
      $display("test flow done");
      romc(4'h4, 9'h000, 32'h080);
      romc(4'h5, 9'h000, 32'h032);
      romc(4'h4, 9'h155, 32'h155);
      romc(4'h8, 9'h140, 32'h006);
      romc(4'h8, 9'h13F, 32'h13F);
      romc(4'h9, 9'h17F, 32'h000);
      romc(4'h9, 9'h17E, 32'h17E);
      wr(A_CTRL, 32'h20);
      romc(4'h4, 9'h1AA, 32'h155);
      $display("test rom done");
      pulse(3);
      pulse(0);
      do_reset();
      $display("test second reset done");
      end_of_test();
   end
endmodule
